// File: dmp_prescaler.sv
// Purpose: Divide-by-10/11 prescaler with APB status and control.
// Assumes: All inputs except presetn and async_preset synchronous to pclk; input_clock_pin is sampled, its rising edge is one input clock.
// Notes: APB answers with zero wait states unless clk_en is low or the read word is not yet latched.
`timescale 1ns/100ps
`include "dmp_consts.svh"
module dmp_prescaler
    import dmp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic input_clock_pin,
    input wire logic count_enable_n,
    input wire logic modulus_select_a,
    input wire logic modulus_select_b,
    input wire logic async_preset,
    output logic single_ended_divided_out,
    output logic divided_out_p,
    output logic divided_out_n
);

    dmp_core_if cif();

    logic ic_prev_reg;
    logic [1:0] ctrl_reg;
    logic [31:0] cycles_reg;
    logic [31:0] div11cnt_reg;
    logic [3:0] len_cnt_reg;
    logic [3:0] lastlen_reg;
    logic track_ok_reg;
    logic rd_valid_reg;
    logic [31:0] prdata_reg;
    logic pslverr_reg;
    logic [31:0] rd_word;
    logic adv;
    logic wr_fire;
    logic any_preset;
    dmp_reg_t wr_sel;

    function automatic dmp_reg_t dmp_decode(input logic [11:0] addr);
        case (addr)
            `DMP_OFF_CTRL: dmp_decode = REG_CTRL;
            `DMP_OFF_STATUS: dmp_decode = REG_STATUS;
            `DMP_OFF_CYCLES: dmp_decode = REG_CYCLES;
            `DMP_OFF_LASTLEN: dmp_decode = REG_LASTLEN;
            `DMP_OFF_DIV11CNT: dmp_decode = REG_DIV11CNT;
            default: dmp_decode = REG_NONE;
        endcase
    endfunction : dmp_decode

    // Core hookup
    assign cif.clk_en = clk_en;
    assign cif.tick = input_clock_pin & ~ic_prev_reg;
    assign cif.hold = count_enable_n | ctrl_reg[`DMP_CTRL_HOLD_BIT];
    assign cif.sw_preset = ctrl_reg[`DMP_CTRL_PRESET_BIT];
    assign cif.div11_sel = ~modulus_select_a & ~modulus_select_b;

    dmp_core u_core
    (
        .pclk(pclk),
        .presetn(presetn),
        .async_preset(async_preset),
        .cif(cif)
    );

    assign single_ended_divided_out = cif.out_q;
    assign divided_out_p = cif.out_q;
    assign divided_out_n = cif.out_qn;

    assign adv = clk_en & cif.tick & ~cif.hold & ~cif.sw_preset;
    assign any_preset = async_preset | cif.sw_preset;

    // Input clock edge detect
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ic_prev_reg <= 1'b0;
        else if (clk_en)
            ic_prev_reg <= input_clock_pin;
    end

    // APB slave
    assign wr_sel = dmp_decode(paddr);
    assign pready = clk_en & rd_valid_reg;
    assign wr_fire = psel & penable & pwrite & pready;
    assign prdata = prdata_reg;
    assign pslverr = pslverr_reg;

    always_comb
    begin
        rd_word = 32'h0000_0000;
        case (dmp_decode(paddr))
            REG_CTRL: rd_word[1:0] = ctrl_reg;
            REG_STATUS:
            begin
                rd_word[`DMP_STAT_STAGE_LSB +: 3] = cif.stages;
                rd_word[`DMP_STAT_OUT_BIT] = cif.out_q;
                rd_word[`DMP_STAT_MODE_BIT] = cif.mode11;
                rd_word[`DMP_STAT_HOLD_BIT] = cif.hold;
                rd_word[`DMP_STAT_SEL_A_BIT] = modulus_select_a;
                rd_word[`DMP_STAT_SEL_B_BIT] = modulus_select_b;
            end
            REG_CYCLES: rd_word = cycles_reg;
            REG_LASTLEN: rd_word[3:0] = lastlen_reg;
            REG_DIV11CNT: rd_word = div11cnt_reg;
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // Read word, or zero in a write, is latched in every selected cycle with clk_en high so it comes from a flop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rd_valid_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            rd_valid_reg <= psel & ~(penable & pready);
            if (psel)
            begin
                prdata_reg <= pwrite ? 32'h0000_0000 : rd_word;
                pslverr_reg <= (wr_sel == REG_NONE) | (pwrite & (wr_sel != REG_CTRL) & (wr_sel != REG_CYCLES)
                    & (wr_sel != REG_DIV11CNT));
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_reg <= `DMP_CTRL_RST;
        else if (wr_fire && wr_sel == REG_CTRL)
            ctrl_reg <= pwdata[1:0];
    end

    // Period counters; a write clears, and a counted output rise in the same cycle leaves the written counter at one
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cycles_reg <= `DMP_CNT_RST;
        else if (cif.rise_now)
            cycles_reg <= (wr_fire && wr_sel == REG_CYCLES) ? 32'h0000_0001 : cycles_reg + 32'h0000_0001;
        else if (wr_fire && wr_sel == REG_CYCLES)
            cycles_reg <= `DMP_CNT_RST;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            div11cnt_reg <= `DMP_CNT_RST;
        else if (cif.rise_now && cif.div11_sel)
            div11cnt_reg <= (wr_fire && wr_sel == REG_DIV11CNT) ? 32'h0000_0001 : div11cnt_reg + 32'h0000_0001;
        else if (wr_fire && wr_sel == REG_DIV11CNT)
            div11cnt_reg <= `DMP_CNT_RST;
    end

    // Input clocks since the last output rise; period length on each rise after the first since reset or preset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            len_cnt_reg <= `DMP_LEN_RST;
            lastlen_reg <= `DMP_LEN_RST;
            track_ok_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            if (any_preset)
            begin
                len_cnt_reg <= `DMP_LEN_RST;
                track_ok_reg <= 1'b0;
            end
            else if (cif.rise_now)
            begin
                len_cnt_reg <= `DMP_LEN_RST;
                track_ok_reg <= 1'b1;
                if (track_ok_reg)
                    lastlen_reg <= len_cnt_reg + 4'h1;
            end
            else if (adv)
                len_cnt_reg <= len_cnt_reg + 4'h1;
        end
    end

    AST_SHIFT: assert property (@(posedge pclk) disable iff (!presetn || async_preset)
        (adv && cif.stages != CNT_HHL && cif.stages != CNT_HHH)
        |=> (cif.stages[1:0] == $past(cif.stages[2:1])))
        else $error("Stages did not shift on an input clock");

    AST_TOGGLE: assert property (@(posedge pclk) disable iff (!presetn || async_preset)
        ($changed(cif.out_q) && !$past(any_preset)) |-> ($past(adv) && cif.stages == CNT_LHH))
        else $error("Output stage changed outside the counter wrap");

    AST_HIGH_TIME: assert property (@(posedge pclk) disable iff (!presetn || async_preset)
        ($fell(cif.out_q) && track_ok_reg && cif.mode11) |-> (len_cnt_reg == `DMP_HIGH_DIV11))
        else $error("Divide-by-eleven high time is not six input clocks");

    AST_HIGH_TIME10: assert property (@(posedge pclk) disable iff (!presetn || async_preset)
        ($fell(cif.out_q) && track_ok_reg && !cif.mode11) |-> (len_cnt_reg == `DMP_HIGH_DIV10))
        else $error("Divide-by-ten high time is not five input clocks");

    AST_PERIOD: assert property (@(posedge pclk) disable iff (!presetn || async_preset)
        (cif.rise_now && track_ok_reg && clk_en && !any_preset)
        |=> (lastlen_reg == ($past(cif.mode11) ? `DMP_PERIOD_DIV11 : `DMP_PERIOD_DIV10)))
        else $error("Output period length does not match the committed mode");

    AST_MODE_STABLE: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(cif.mode11) |-> $past(cif.rise_now))
        else $error("Period length decision changed mid-period");

    AST_SAMPLE: assert property (@(posedge pclk) disable iff (!presetn)
        cif.rise_now |=> (cif.mode11 == (!$past(modulus_select_a) && !$past(modulus_select_b))))
        else $error("Selects not sampled at the edge after HHLL");

    AST_PRESET: assert property (@(posedge pclk) disable iff (!presetn)
        async_preset |-> (cif.stages == CNT_HHH && cif.out_q))
        else $error("Preset did not force all stages high");

    AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn || async_preset)
        (cif.hold && !cif.sw_preset) |=> ($stable(cif.stages) && $stable(cif.out_q)))
        else $error("Stages moved while held");

    AST_WRAP: assert property (@(posedge pclk) disable iff (!presetn || async_preset)
        (adv && cif.stages == CNT_HHL && !cif.out_q) |=> (cif.stages == CNT_LHH && cif.out_q))
        else $error("Extra state inserted in the low half");

    AST_COMPL: assert property (@(posedge pclk) disable iff (!presetn) divided_out_n == !divided_out_p)
        else $error("Complementary output is not the inverse");

    COV_DIV11: cover property (@(posedge pclk) disable iff (!presetn)
        cif.rise_now && track_ok_reg && lastlen_reg == `DMP_PERIOD_DIV11);
    COV_DIV10: cover property (@(posedge pclk) disable iff (!presetn)
        cif.rise_now && track_ok_reg && lastlen_reg == `DMP_PERIOD_DIV10);
    COV_HOLD: cover property (@(posedge pclk) disable iff (!presetn)
        cif.hold && cif.tick && clk_en);
    COV_PRESET: cover property (@(posedge pclk) disable iff (!presetn)
        $fell(async_preset));

endmodule : dmp_prescaler

// File: dmp_consts.svh
// Purpose: Constants for the dual-modulus prescaler: register offsets, fields, reset values, counts.
// Assumes: APB byte addresses, 32-bit data, one aligned word per register.
// Notes: Included by bare name; definitions only.
`ifndef DMP_CONSTS_SVH
`define DMP_CONSTS_SVH

`define DMP_OFF_CTRL 12'h000
`define DMP_OFF_STATUS 12'h004
`define DMP_OFF_CYCLES 12'h008
`define DMP_OFF_LASTLEN 12'h00c
`define DMP_OFF_DIV11CNT 12'h010

`define DMP_CTRL_HOLD_BIT 0
`define DMP_CTRL_PRESET_BIT 1
`define DMP_CTRL_RST 2'h0

`define DMP_STAT_STAGE_LSB 0
`define DMP_STAT_OUT_BIT 3
`define DMP_STAT_MODE_BIT 4
`define DMP_STAT_HOLD_BIT 5
`define DMP_STAT_SEL_A_BIT 6
`define DMP_STAT_SEL_B_BIT 7

`define DMP_CNT_RST 32'h0000_0000
`define DMP_LEN_RST 4'h0
`define DMP_HIGH_DIV11 4'h6
`define DMP_HIGH_DIV10 4'h5
`define DMP_PERIOD_DIV11 4'hb
`define DMP_PERIOD_DIV10 4'ha

`endif

// File: dmp_pkg.sv
// Purpose: Types shared by the prescaler core, its carrier and the top.
// Assumes: Stage code is {stage_one, stage_two, stage_three}.
// Notes: Only types live here; numbers are in dmp_consts.svh.
package dmp_pkg;

    typedef enum logic [2:0] {
        CNT_LLL = 3'b000,
        CNT_LLH = 3'b001,
        CNT_LHH = 3'b011,
        CNT_HLL = 3'b100,
        CNT_HHL = 3'b110,
        CNT_HHH = 3'b111
    } dmp_cnt_t;

    typedef enum logic [2:0] {
        REG_CTRL = 3'b000,
        REG_STATUS = 3'b001,
        REG_CYCLES = 3'b010,
        REG_LASTLEN = 3'b011,
        REG_DIV11CNT = 3'b100,
        REG_NONE = 3'b111
    } dmp_reg_t;

endpackage : dmp_pkg

// File: dmp_core_if.sv
// Purpose: Carrier between the prescaler top and its counter core.
// Assumes: All signals belong to the pclk domain.
// Notes: rise_now is combinational and marks the advance that raises the output.
`timescale 1ns/100ps
interface dmp_core_if;
    logic clk_en;
    logic tick;
    logic hold;
    logic sw_preset;
    logic div11_sel;
    dmp_pkg::dmp_cnt_t stages;
    logic out_q;
    logic out_qn;
    logic mode11;
    logic rise_now;

    modport core
    (
        input clk_en,
        input tick,
        input hold,
        input sw_preset,
        input div11_sel,
        output stages,
        output out_q,
        output out_qn,
        output mode11,
        output rise_now
    );

    modport ctrl
    (
        output clk_en,
        output tick,
        output hold,
        output sw_preset,
        output div11_sel,
        input stages,
        input out_q,
        input out_qn,
        input mode11,
        input rise_now
    );
endinterface : dmp_core_if

// File: dmp_core.sv
// Purpose: Three-stage shift counter plus toggling output stage.
// Assumes: tick marks one input clock; async_preset may arrive at any time.
// Notes: The length decision is latched at the output rise and read only at HHL.
`timescale 1ns/100ps
module dmp_core
    import dmp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic async_preset,
    dmp_core_if.core cif
);

    dmp_cnt_t stage_reg;
    dmp_cnt_t stage_next;
    logic out_reg;
    logic out_n_reg;
    logic mode11_reg;
    logic advance;
    logic toggle;

    assign advance = cif.clk_en & cif.tick & ~cif.hold;
    assign toggle = advance & (stage_next == CNT_LHH);
    assign cif.rise_now = toggle & ~out_reg & ~cif.sw_preset;

    always_comb
    begin
        stage_next = stage_reg;
        case (stage_reg)
            CNT_LHH: stage_next = CNT_LLH;
            CNT_LLH: stage_next = CNT_LLL;
            CNT_LLL: stage_next = CNT_HLL;
            CNT_HLL: stage_next = CNT_HHL;
            CNT_HHL:
            begin
                // Extra all-high state only in the high half of an eleven period
                if (out_reg && mode11_reg)
                    stage_next = CNT_HHH;
                else
                    stage_next = CNT_LHH;
            end
            CNT_HHH: stage_next = CNT_LHH;
            default: stage_next = CNT_HHH;
        endcase
    end

    // Shift counter; preset forces all high ahead of everything
    always_ff @(posedge pclk or negedge presetn or posedge async_preset)
    begin
        if (!presetn)
            stage_reg <= CNT_HHH;
        else if (async_preset)
            stage_reg <= CNT_HHH;
        else if (cif.clk_en)
        begin
            if (cif.sw_preset)
                stage_reg <= CNT_HHH;
            else if (advance)
                stage_reg <= stage_next;
        end
    end

    // Output stage and its complement move together
    always_ff @(posedge pclk or negedge presetn or posedge async_preset)
    begin
        if (!presetn)
        begin
            out_reg <= 1'b1;
            out_n_reg <= 1'b0;
        end
        else if (async_preset)
        begin
            out_reg <= 1'b1;
            out_n_reg <= 1'b0;
        end
        else if (cif.clk_en)
        begin
            if (cif.sw_preset)
            begin
                out_reg <= 1'b1;
                out_n_reg <= 1'b0;
            end
            else if (toggle)
            begin
                out_reg <= ~out_reg;
                out_n_reg <= out_reg;
            end
        end
    end

    // Select sampled on the edge leaving HHLL, which is the output rise
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mode11_reg <= 1'b0;
        else if (cif.rise_now)
            mode11_reg <= cif.div11_sel;
    end

    assign cif.stages = stage_reg;
    assign cif.out_q = out_reg;
    assign cif.out_qn = out_n_reg;
    assign cif.mode11 = mode11_reg;

endmodule : dmp_core

// File: dmp_swallow_model.sv
// Purpose: Pulse-swallow counter logic that drives the two modulus selects from the divided output.
// Assumes: Acts on the output rising edge, or the falling edge when use_fall is set, sampled on pclk; frame is never zero.
// Notes: Glitch mode drives the opposite mode during the period and the real one only after lag.
`timescale 1ns/100ps
module dmp_swallow_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic div_out,
    input wire logic [3:0] swallow,
    input wire logic [3:0] frame,
    input wire logic [7:0] lag,
    input wire logic use_b,
    input wire logic glitch,
    input wire logic use_fall,
    output logic sel_a,
    output logic sel_b
);
    logic out_d;
    logic pend;
    logic want11;
    logic [3:0] rise_cnt;
    logic [3:0] nxt;
    logic [7:0] wait_cnt;
    logic trig;

    // Active edge of the divided output; the falling edge leaves only the low half
    assign trig = use_fall ? (!div_out && out_d) : (div_out && !out_d);

    assign nxt = (rise_cnt + 4'h1 >= frame) ? 4'h0 : rise_cnt + 4'h1;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            out_d <= 1'b1;
            pend <= 1'b0;
            want11 <= 1'b0;
            rise_cnt <= 4'h0;
            wait_cnt <= 8'h00;
            sel_a <= 1'b1;
            sel_b <= 1'b0;
        end
        else
        begin
            out_d <= div_out;
            if (trig)
            begin
                // Swallow one extra input clock in the first periods of each frame
                rise_cnt <= nxt;
                want11 <= (nxt < swallow);
                wait_cnt <= lag;
                pend <= 1'b1;
                if (glitch)
                begin
                    sel_a <= ~(sel_a | sel_b);
                    sel_b <= 1'b0;
                end
            end
            else if (pend && wait_cnt != 8'h00)
                wait_cnt <= wait_cnt - 8'h01;
            else if (pend)
            begin
                // Both low asks for eleven, one high for ten
                pend <= 1'b0;
                sel_a <= ~want11 & ~use_b;
                sel_b <= ~want11 & use_b;
            end
        end
    end
endmodule : dmp_swallow_model

// File: tb_dual_modulus_prescaler.sv
// Purpose: Self-checking bench for the dual-modulus prescaler.
// Assumes: One input clock every five pclk cycles; clk_en stays high.
// Notes: Period lengths are counted in input clocks made by the bench.
`timescale 1ns/100ps
module tb_dual_modulus_prescaler;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic clk_en = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic input_clock_pin = 1'b0;
    logic count_enable_n = 1'b0;
    logic sel_a;
    logic sel_b;
    logic async_preset = 1'b0;
    logic se_out;
    logic out_p;
    logic out_n;
    logic [3:0] swallow = 4'h1;
    logic [3:0] frame = 4'h1;
    logic [7:0] lag = 8'h00;
    logic use_b = 1'b0;
    logic glitch = 1'b0;
    logic use_fall = 1'b0;
    int failures = 0;
    int comparisons = 0;
    int cyc = 0;
    logic [31:0] rd;
    logic er;

    dmp_prescaler dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .input_clock_pin(input_clock_pin), .count_enable_n(count_enable_n), .modulus_select_a(sel_a),
        .modulus_select_b(sel_b), .async_preset(async_preset), .single_ended_divided_out(se_out),
        .divided_out_p(out_p), .divided_out_n(out_n));

    dmp_swallow_model swallow_logic (.pclk(pclk), .presetn(presetn), .div_out(se_out), .swallow(swallow),
        .frame(frame), .lag(lag), .use_b(use_b), .glitch(glitch), .use_fall(use_fall), .sel_a(sel_a),
        .sel_b(sel_b));

    initial
    begin
        forever #4 pclk = ~pclk;
    end

    task end_of_test;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_of_test

    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            failures++;
            end_of_test();
        end
    end

    // Outputs must agree every cycle, through preset and hold as well
    always @(negedge pclk)
    begin
        if (presetn)
            check(32'({out_n, se_out}), 32'({~out_p, out_p}));
    end

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Answer is taken at the edge where pready is seen high, then released
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task adv;
        @(posedge pclk);
        input_clock_pin <= 1'b1;
        repeat (2) @(posedge pclk);
        input_clock_pin <= 1'b0;
        repeat (2) @(posedge pclk);
        @(negedge pclk);
    endtask : adv

    task run_until(input logic lvl, output int n);
        n = 0;
        while (se_out !== lvl && n < 20)
        begin
            adv();
            n++;
        end
    endtask : run_until

    task t_div_modes;
        logic [3:0] cfg [3] = '{4'h1, 4'h0, 4'h0};
        logic ub [3] = '{1'b0, 1'b0, 1'b1};
        int h;
        int l;
        for (int c = 0; c < 3; c++)
        begin
            swallow <= cfg[c];
            use_b <= ub[c];
            repeat (3)
            begin
                run_until(1'b0, h);
                run_until(1'b1, l);
            end
            repeat (2)
            begin
                run_until(1'b0, h);
                run_until(1'b1, l);
                check(32'(h), (cfg[c] != 4'h0) ? 32'h6 : 32'h5);
                check(32'(l), 32'h5);
                apb(1'b0, 12'h00c, 32'h0);
                check({28'h0, rd[3:0]}, (cfg[c] != 4'h0) ? 32'hb : 32'ha);
            end
        end
        $display("t_div_modes done");
    endtask : t_div_modes

    task t_sequence;
        logic [3:0] exp [12] = '{4'h3, 4'h1, 4'h0, 4'h4, 4'h6, 4'hb, 4'h9, 4'h8, 4'hc, 4'he, 4'hf, 4'h3};
        int n;
        swallow <= 4'h1;
        // One full period so the partner asks for eleven before the preset
        run_until(1'b0, n);
        run_until(1'b1, n);
        @(posedge pclk);
        async_preset <= 1'b1;
        repeat (2) @(posedge pclk);
        async_preset <= 1'b0;
        for (int i = 0; i < 12; i++)
        begin
            adv();
            apb(1'b0, 12'h004, 32'h0);
            check({28'h0, rd[3:0]}, {28'h0, exp[i]});
        end
        $display("t_sequence done");
    endtask : t_sequence

    task t_swallow;
        int h;
        int l;
        int sum;
        int n11;
        frame <= 4'h4;
        lag <= 8'h1e;
        glitch <= 1'b1;
        repeat (5)
        begin
            run_until(1'b0, h);
            run_until(1'b1, l);
        end
        sum = 0;
        n11 = 0;
        repeat (8)
        begin
            run_until(1'b0, h);
            run_until(1'b1, l);
            sum += h + l;
            n11 += (h + l == 11) ? 1 : 0;
        end
        check(32'(sum), 32'd82);
        check(32'(n11), 32'h2);
        glitch <= 1'b0;
        lag <= 8'h0a;
        use_fall <= 1'b1;
        repeat (3)
        begin
            run_until(1'b0, h);
            run_until(1'b1, l);
        end
        sum = 0;
        repeat (8)
        begin
            run_until(1'b0, h);
            run_until(1'b1, l);
            sum += h + l;
        end
        check(32'(sum), 32'd82);
        use_fall <= 1'b0;
        lag <= 8'h00;
        $display("t_swallow done");
    endtask : t_swallow

    task t_hold_preset;
        logic [31:0] s0;
        int n;
        count_enable_n <= 1'b1;
        apb(1'b0, 12'h004, 32'h0);
        s0 = rd;
        repeat (4) adv();
        apb(1'b0, 12'h004, 32'h0);
        check({24'h0, rd[7:0]}, {24'h0, s0[7:0]});
        count_enable_n <= 1'b0;
        apb(1'b1, 12'h000, 32'h1);
        apb(1'b0, 12'h004, 32'h0);
        s0 = rd;
        repeat (3) adv();
        apb(1'b0, 12'h004, 32'h0);
        check({28'h0, rd[3:0]}, {28'h0, s0[3:0]});
        count_enable_n <= 1'b1;
        async_preset <= 1'b1;
        repeat (2) adv();
        check(32'({se_out, out_p, out_n}), 32'h6);
        apb(1'b0, 12'h004, 32'h0);
        check({28'h0, rd[3:0]}, 32'hf);
        async_preset <= 1'b0;
        count_enable_n <= 1'b0;
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b0, 12'h020, 32'h0);
        check({rd[30:0], er}, 32'h1);
        apb(1'b1, 12'h004, 32'h5);
        check(32'(er), 32'h1);
        apb(1'b1, 12'h008, 32'h0);
        apb(1'b0, 12'h008, 32'h0);
        check(rd, 32'h0);
        run_until(1'b0, n);
        run_until(1'b1, n);
        apb(1'b0, 12'h008, 32'h0);
        check(rd, 32'h1);
        $display("t_hold_preset done");
    endtask : t_hold_preset

    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        check(32'({se_out, out_p, out_n}), 32'h6);
        t_div_modes();
        t_sequence();
        t_swallow();
        t_hold_preset();
        end_of_test();
    end
endmodule : tb_dual_modulus_prescaler
